//--- shared/spfe_pkg.sv
// package: constants, encodings and types of the paged flash front end
// Functional notes
// (RULE1) output bit changes after falling clock edge
// (RULE2) input sampled on rising edge, msb first
// (RULE3) deselected: output high impedance, clock ignored
// (RULE4) standby only after internal cycle ends
// (RULE5) first select fall needed before any instruction
// (RULE6) reset low: output high impedance, all idle
// (RULE7) reset during cycle disturbs it; master avoids
// (RULE8) eight sectors of sixteen subsectors decoded
// (RULE9) 2048 pages of 256 bytes, contiguous
// (RULE10) page load takes 1 to 256 bytes
// (RULE11) page write erases then programs; program only
// (RULE12) four erase scopes, each own instruction
// (RULE13) protection in whole 64-kilobyte sectors
// (RULE14) every 4-kilobyte subsector erasable alone
// (RULE15) only protect bits and disable bit writable
// (RULE16) write protect pin freezes protected area
// (RULE17) both clock idle levels accepted
// (RULE18) busy flag readable while cycle runs
// (RULE19) select rising mid-byte aborts instruction
package spfe_pkg;

  // array organisation
  localparam int         ADDR_W         = 19;
  localparam int         SECTORS        = 8;
  localparam int         SUBS_PER_SECT  = 16;
  localparam int         PAGES_PER_SECT = 256;
  localparam int         PAGES_PER_SUB  = 16;
  localparam int         PAGE_BYTES     = 256;
  localparam int         PAGES          = 2048;
  localparam logic [3:0] SECTOR_CNT     = 4'h8;
  localparam logic [8:0] PAGE_FULL_CNT  = 9'h100;

  // address masks per erase scope
  localparam logic [18:0] PAGE_MASK   = 19'h7ff00;
  localparam logic [18:0] SUB_MASK    = 19'h7f000;
  localparam logic [18:0] SECTOR_MASK = 19'h70000;

  // address field positions
  localparam int SECTOR_LSB = 16;
  localparam int SUB_LSB    = 12;
  localparam int PAGE_LSB   = 8;

  // instruction codes
  localparam logic [7:0] CMD_WRITE_EN          = 8'h11;
  localparam logic [7:0] CMD_WRITE_DIS         = 8'h12;
  localparam logic [7:0] CMD_STATUS_READ       = 8'h13;
  localparam logic [7:0] CMD_STATUS_WRITE      = 8'h14;
  localparam logic [7:0] CMD_PAGE_WRITE        = 8'h15;
  localparam logic [7:0] CMD_PAGE_PROG         = 8'h16;
  localparam logic [7:0] CMD_PAGE_ERASE        = 8'h17;
  localparam logic [7:0] CMD_SUBSECTOR_ERASE   = 8'h18;
  localparam logic [7:0] CMD_SECTOR_ERASE      = 8'h19;
  localparam logic [7:0] CMD_WHOLE_ARRAY_ERASE = 8'h1a;

  // status byte layout and reset values
  localparam int         STAT_BUSY_POS = 0;
  localparam int         STAT_WEL_POS  = 1;
  localparam int         STAT_BP_POS   = 2;
  localparam int         STAT_SWD_POS  = 7;
  localparam logic [2:0] BP_RST        = 3'h0;
  localparam logic       SWD_RST       = 1'b0;

  // internal cycle kinds
  typedef enum logic [2:0] {
    OP_PAGE_ERASE        = 3'h0,
    OP_PAGE_PROG         = 3'h1,
    OP_SUBSECTOR_ERASE   = 3'h2,
    OP_SECTOR_ERASE      = 3'h3,
    OP_WHOLE_ARRAY_ERASE = 3'h4
  } spfe_op_e;

  // byte phase inside a frame
  typedef enum logic [2:0] {
    PH_OPC  = 3'h0,
    PH_ADDR = 3'h1,
    PH_DATA = 3'h2,
    PH_STAT = 3'h3,
    PH_IGN  = 3'h4
  } spfe_ph_e;

  // core state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } spfe_st_e;

endpackage : spfe_pkg

//--- design/spfe_sync3.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module spfe_sync3 import spfe_pkg::*; #(
  parameter int W = 1
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // foreign level in, filtered level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } spfe_sync_s;

  spfe_sync_s r;
  spfe_sync_s next_r;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q  = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.q;

endmodule : spfe_sync3

//--- design/spfe_buf2.sv
// small valid/ready buffer, two entries by default
`timescale 1ns/1ps
module spfe_buf2 import spfe_pkg::*; #(
  parameter int W     = 17,
  parameter int DEPTH = 2
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    full;
    logic                    has;
  } spfe_buf_s;

  spfe_buf_s r;
  spfe_buf_s next_r;

  always_comb begin
    logic push;
    logic pop;
    push   = in_valid && !r.full;
    pop    = out_ready && r.has;
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp        = (r.wp == LAST) ? '0 : r.wp + AW'(1);
    end
    if (pop) begin
      next_r.rp = (r.rp == LAST) ? '0 : r.rp + AW'(1);
    end
    next_r.cnt  = r.cnt + CW'(push) - CW'(pop);
    next_r.full = (next_r.cnt == FULL);
    next_r.has  = (next_r.cnt != '0);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign in_ready  = !r.full;
  assign out_valid = r.has;
  assign out_data  = r.mem[r.rp];

endmodule : spfe_buf2

//--- design/spfe_top.sv
// serial front end of the paged flash: link domain and core domain
`timescale 1ns/1ps
module spfe_top import spfe_pkg::*; #(
  parameter int BUF_DEPTH = 2
) (
  // core clock and control
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  // serial link
  input  wire logic              sclk,
  input  wire logic              sel_n,
  input  wire logic              mosi,
  output logic                   miso,
  output logic                   miso_oe_n,
  input  wire logic              write_protect_n,
  // page data stream to the array
  output logic                   dat_valid,
  input  wire logic              dat_ready,
  output logic                   dat_first,
  output logic [7:0]             dat_col,
  output logic [7:0]             dat_byte,
  // internal cycle requests
  output logic                   op_valid,
  input  wire logic              op_ready,
  output spfe_op_e               op_kind,
  output logic [ADDR_W-1:0]      op_addr,
  input  wire logic              op_done,
  // status levels
  output logic                   cycle_busy_flag,
  output logic                   standby,
  output logic                   write_latch,
  output logic                   protect_area_bit0,
  output logic                   protect_area_bit1,
  output logic                   protect_area_bit2,
  output logic                   status_write_disable,
  output logic                   overrun
);

  // ---------------- core state ----------------
  typedef struct packed {
    logic        oe_n;
    spfe_ph_e    ph;
    logic        frame;
    logic        sel_q;
    logic        tog_q;
    logic [2:0]  bits;
    logic [1:0]  nab;
    logic [7:0]  opc;
    logic [23:0] addr;
    logic [7:0]  col;
    logic [8:0]  dcnt;
    logic        first;
    logic [7:0]  stat_new;
    logic        have_stat;
    logic        wel;
    logic [2:0]  bp;
    logic        swd;
    logic [7:0]  snap;
    spfe_st_e    st;
    logic        pw;
    logic        busy;
    logic        standby;
    logic        overrun;
    logic        pend;
    logic [16:0] pend_w;
    logic        op_valid;
    spfe_op_e    op_kind;
    logic [18:0] op_addr;
  } spfe_core_s;

  localparam int CORE_W = $bits(spfe_core_s);
  localparam spfe_core_s CORE_RST =
    spfe_core_s'({1'b1, {(CORE_W - 1){1'b0}}});

  spfe_core_s c;
  spfe_core_s next_c;

  // ---------------- link state ----------------
  typedef struct packed {
    logic [2:0] bitcnt;
    logic [6:0] shift;
    logic [7:0] rx_hold;
    logic       bit_tog;
    logic       opc_done;
    logic       rd_stat;
    logic [7:0] tx_byte;
  } spfe_link_s;

  spfe_link_s lk;
  spfe_link_s next_lk;

  logic [1:0]  pin_q;
  logic        tog_s;
  logic        buf_in_ready;
  logic [16:0] buf_out;

  // link side: every rising edge shifts one bit in
  always_comb begin
    next_lk         = lk;
    next_lk.bit_tog = ~lk.bit_tog;
    next_lk.bitcnt  = lk.bitcnt + 3'h1;
    next_lk.shift   = {lk.shift[5:0], mosi};  // see RULE2
    if (lk.bitcnt == 3'h7) begin
      next_lk.rx_hold  = {lk.shift, mosi};
      next_lk.opc_done = 1'b1;
      if (!lk.opc_done && {lk.shift, mosi} == CMD_STATUS_READ) begin
        next_lk.rd_stat = 1'b1;
      end
      // snap is frozen by the core for the whole frame
      next_lk.tx_byte = next_lk.rd_stat ? c.snap : 8'h00;  // see RULE18
    end
  end

  // deselect clears the link at once; sclk may stand still then
  always_ff @(posedge sclk or posedge sel_n) begin  // see RULE3
    if (sel_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // idle-high clock gives a harmless first falling edge
  always_ff @(negedge sclk or posedge sel_n) begin  // see RULE1, RULE17
    if (sel_n) begin
      miso <= 1'b0;
    end else begin
      miso <= lk.tx_byte[3'h7 - lk.bitcnt];
    end
  end

  // ---------------- crossings into the core ----------------
  spfe_sync3 #(.W(2)) u_pin_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     ({write_protect_n, sel_n}),
    .q     (pin_q)
  );

  // one toggle per serial bit; bytes are counted here
  spfe_sync3 #(.W(1)) u_tog_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     (lk.bit_tog),
    .q     (tog_s)
  );

  // protected top sectors for a protect-bit setting
  function automatic logic area_locked(input logic [2:0] bp,
                                       input logic [2:0] sector);
    logic [3:0] n;
    case (bp)
      3'h0:    n = 4'h0;
      3'h1:    n = 4'h1;
      3'h2:    n = 4'h2;
      3'h3:    n = 4'h4;
      default: n = SECTOR_CNT;
    endcase
    area_locked = {1'b0, sector} >= (SECTOR_CNT - n);  // see RULE13
  endfunction : area_locked

  // ---------------- core logic ----------------
  always_comb begin
    logic       sel_now;
    logic       wp_now;
    logic       bit_ev;
    logic       byte_ev;
    logic       is_op;
    logic       legal;
    logic       hit;
    logic [7:0] b;
    spfe_op_e   kind;
    logic [18:0] mask;
    sel_now = pin_q[0];
    wp_now  = pin_q[1];
    bit_ev  = c.frame && (tog_s != c.tog_q);
    byte_ev = bit_ev && (c.bits == 3'h7);
    b       = lk.rx_hold;
    is_op   = 1'b0;
    legal   = 1'b0;
    hit     = area_locked(c.bp, c.addr[SECTOR_LSB +: 3]);
    kind    = OP_PAGE_ERASE;
    mask    = PAGE_MASK;
    next_c  = c;

    next_c.sel_q = sel_now;
    next_c.tog_q = tog_s;
    if (c.pend && buf_in_ready) begin
      next_c.pend = 1'b0;
    end

    // sel_q resets low: a select already low never opens a frame
    if (c.sel_q && !sel_now) begin  // see RULE5
      next_c.frame     = 1'b1;
      next_c.ph        = PH_OPC;
      next_c.bits      = 3'h0;
      next_c.nab       = 2'h0;
      next_c.dcnt      = 9'h000;
      next_c.first     = 1'b1;
      next_c.have_stat = 1'b0;
      next_c.opc       = 8'h00;
    end

    if (bit_ev) begin
      next_c.bits = c.bits + 3'h1;
    end

    if (byte_ev) begin
      case (c.ph)
        PH_OPC: begin
          next_c.opc = b;
          next_c.ph  = PH_IGN;
          // while busy only the status read is served, by the link
          if (c.st == ST_IDLE) begin  // see RULE18
            if (b == CMD_PAGE_WRITE || b == CMD_PAGE_PROG ||
                b == CMD_PAGE_ERASE || b == CMD_SUBSECTOR_ERASE ||
                b == CMD_SECTOR_ERASE) begin
              next_c.ph = PH_ADDR;
            end else if (b == CMD_STATUS_WRITE) begin
              next_c.ph = PH_STAT;
            end
          end
        end
        PH_ADDR: begin
          next_c.addr = {c.addr[15:0], b};  // see RULE2
          next_c.nab  = c.nab + 2'h1;
          if (c.nab == 2'h2) begin
            next_c.col = b;
            if (c.opc == CMD_PAGE_WRITE || c.opc == CMD_PAGE_PROG) begin
              next_c.ph = PH_DATA;
            end else begin
              next_c.ph = PH_IGN;
            end
          end
        end
        PH_DATA: begin
          // the buffer absorbs array stalls; this flags a lost byte
          if (c.pend && !buf_in_ready) begin
            next_c.overrun = 1'b1;
          end
          next_c.pend   = 1'b1;
          next_c.pend_w = {c.first, c.col, b};
          next_c.first  = 1'b0;
          next_c.col    = c.col + 8'h01;  // see RULE9, RULE10
          if (c.dcnt != PAGE_FULL_CNT) begin
            next_c.dcnt = c.dcnt + 9'h001;  // see RULE10
          end
        end
        PH_STAT: begin
          next_c.stat_new  = b;
          next_c.have_stat = 1'b1;
          next_c.ph        = PH_IGN;
        end
        default: begin
          next_c.ph = PH_IGN;
        end
      endcase
    end

    // end of frame: commit only whole-byte instructions
    if (c.frame && sel_now) begin
      next_c.frame = 1'b0;
      if (c.bits == 3'h0 && c.st == ST_IDLE) begin  // see RULE19
        if (c.opc == CMD_WRITE_EN) begin
          next_c.wel = 1'b1;
        end else if (c.opc == CMD_WRITE_DIS) begin
          next_c.wel = 1'b0;
        end else if (c.opc == CMD_STATUS_WRITE && c.have_stat) begin
          next_c.wel = 1'b0;
          // pin low with disable set freezes the protected area
          if (c.wel && !(c.swd && !wp_now)) begin  // see RULE16
            next_c.bp  = c.stat_new[STAT_BP_POS +: 3];  // see RULE15
            next_c.swd = c.stat_new[STAT_SWD_POS];  // see RULE15
          end
        end

        legal = c.wel && !hit && (c.nab == 2'h3);
        if (c.opc == CMD_PAGE_WRITE) begin
          is_op = 1'b1;
          legal = legal && (c.dcnt != 9'h000);
          kind  = OP_PAGE_ERASE;  // see RULE11
        end else if (c.opc == CMD_PAGE_PROG) begin
          is_op = 1'b1;
          legal = legal && (c.dcnt != 9'h000);
          kind  = OP_PAGE_PROG;  // see RULE11
        end else if (c.opc == CMD_PAGE_ERASE) begin
          is_op = 1'b1;
          kind  = OP_PAGE_ERASE;  // see RULE12
        end else if (c.opc == CMD_SUBSECTOR_ERASE) begin
          is_op = 1'b1;
          kind  = OP_SUBSECTOR_ERASE;  // see RULE12, RULE14
          mask  = SUB_MASK;
        end else if (c.opc == CMD_SECTOR_ERASE) begin
          is_op = 1'b1;
          kind  = OP_SECTOR_ERASE;  // see RULE12
          mask  = SECTOR_MASK;
        end else if (c.opc == CMD_WHOLE_ARRAY_ERASE) begin
          is_op = 1'b1;
          legal = c.wel && (c.bp == 3'h0);  // see RULE12
          kind  = OP_WHOLE_ARRAY_ERASE;
          mask  = 19'h00000;
        end else begin
          legal = 1'b0;
        end

        if (is_op) begin
          next_c.wel = 1'b0;
        end
        if (is_op && legal) begin
          next_c.st       = ST_EXEC;
          next_c.busy     = 1'b1;
          next_c.op_valid = 1'b1;
          next_c.op_kind  = kind;
          next_c.op_addr  = c.addr[ADDR_W-1:0] & mask;  // see RULE8
          next_c.pw       = (c.opc == CMD_PAGE_WRITE);
        end
      end
    end

    // internal cycle: page write chains its program step
    if (c.st == ST_EXEC) begin
      if (c.op_valid && op_ready) begin
        next_c.op_valid = 1'b0;
      end
      if (op_done && !c.op_valid) begin
        if (c.pw) begin
          next_c.pw       = 1'b0;
          next_c.op_valid = 1'b1;
          next_c.op_kind  = OP_PAGE_PROG;  // see RULE11
        end else begin
          next_c.st   = ST_IDLE;
          next_c.busy = 1'b0;
        end
      end
    end

    next_c.standby = sel_now && !next_c.busy;  // see RULE4
    next_c.oe_n    = !next_c.frame;  // see RULE3
    if (!next_c.frame) begin
      next_c.snap                = 8'h00;
      next_c.snap[STAT_BUSY_POS] = next_c.busy;
      next_c.snap[STAT_WEL_POS]  = next_c.wel;
      next_c.snap[STAT_BP_POS +: 3] = next_c.bp;
      next_c.snap[STAT_SWD_POS]  = next_c.swd;
    end
  end

  // reset drops any running cycle request and floats the output
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      c <= CORE_RST;  // see RULE6, RULE7
    end else if (ce) begin
      c <= next_c;
    end
  end

  // ---------------- page data buffer ----------------
  spfe_buf2 #(.W(17), .DEPTH(BUF_DEPTH)) u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (c.pend),
    .in_ready  (buf_in_ready),
    .in_data   (c.pend_w),
    .out_valid (dat_valid),
    .out_ready (dat_ready),
    .out_data  (buf_out)
  );

  assign dat_first            = buf_out[16];
  assign dat_col              = buf_out[15:8];
  assign dat_byte             = buf_out[7:0];
  assign miso_oe_n            = c.oe_n;
  assign op_valid             = c.op_valid;
  assign op_kind              = c.op_kind;
  assign op_addr              = c.op_addr;
  assign cycle_busy_flag      = c.busy;
  assign standby              = c.standby;
  assign write_latch          = c.wel;
  assign protect_area_bit0    = c.bp[0];
  assign protect_area_bit1    = c.bp[1];
  assign protect_area_bit2    = c.bp[2];
  assign status_write_disable = c.swd;
  assign overrun              = c.overrun;

endmodule : spfe_top

//--- dv/spfe_sva.sv
// assertion checker watching the paged flash front end ports
`timescale 1ns/1ps
module spfe_sva import spfe_pkg::*; #(
  parameter int BUF_DEPTH = 2
) (
  // core
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  // link
  input wire logic        sclk,
  input wire logic        sel_n,
  input wire logic        mosi,
  input wire logic        miso,
  input wire logic        miso_oe_n,
  input wire logic        write_protect_n,
  // data stream
  input wire logic        dat_valid,
  input wire logic        dat_ready,
  input wire logic        dat_first,
  input wire logic [7:0]  dat_col,
  input wire logic [7:0]  dat_byte,
  // cycle requests
  input wire logic        op_valid,
  input wire logic        op_ready,
  input spfe_op_e         op_kind,
  input wire logic [18:0] op_addr,
  input wire logic        op_done,
  // status
  input wire logic        cycle_busy_flag,
  input wire logic        standby,
  input wire logic        write_latch,
  input wire logic        protect_area_bit0,
  input wire logic        protect_area_bit1,
  input wire logic        protect_area_bit2,
  input wire logic        status_write_disable,
  input wire logic        overrun
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_quiet8;
    (rst_b && sel_n && !cycle_busy_flag)[*8];
  endsequence
  sequence s_frozen6;
    (status_write_disable && !write_protect_n)[*6];
  endsequence
  property p_rst_out;
    $rose(rst_b) |-> miso_oe_n && !op_valid && !cycle_busy_flag
      && !write_latch && !dat_valid;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs active just after reset");
  property p_sel_off;
    (rst_b && sel_n)[*8] |-> miso_oe_n;
  endproperty
  a_sel_off: assert property (p_sel_off)
    else $error("output driven while deselected");
  property p_stby;
    s_quiet8 |-> standby;
  endproperty
  a_stby: assert property (p_stby)
    else $error("no standby while idle and deselected");
  property p_busy_stby;
    cycle_busy_flag ##1 cycle_busy_flag |-> !standby;
  endproperty
  a_busy_stby: assert property (p_busy_stby)
    else $error("standby during internal cycle");
  property p_op_hold;
    op_valid && !op_ready |=> op_valid && $stable(op_kind)
      && $stable(op_addr);
  endproperty
  a_op_hold: assert property (p_op_hold)
    else $error("cycle request dropped or changed");
  property p_op_align;
    op_valid |-> op_kind <= OP_WHOLE_ARRAY_ERASE && (op_addr & ~(
      (op_kind == OP_SECTOR_ERASE) ? SECTOR_MASK :
      (op_kind == OP_SUBSECTOR_ERASE) ? SUB_MASK :
      (op_kind == OP_WHOLE_ARRAY_ERASE) ? 19'h00000 : PAGE_MASK)) == 19'h0;
  endproperty
  a_op_align: assert property (p_op_align)
    else $error("cycle address not aligned to its scope");
  property p_commit;
    $rose(cycle_busy_flag) |-> sel_n;
  endproperty
  a_commit: assert property (p_commit)
    else $error("internal cycle started inside a frame");
  property p_dat_hold;
    dat_valid && !dat_ready |=> dat_valid && $stable(dat_byte)
      && $stable(dat_col) && $stable(dat_first);
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("stalled data byte lost or changed");
  property p_wp_freeze;
    s_frozen6 |=> $stable({protect_area_bit2, protect_area_bit1,
      protect_area_bit0, status_write_disable});
  endproperty
  a_wp_freeze: assert property (p_wp_freeze)
    else $error("protect bits changed under write protect");
endmodule : spfe_sva
bind spfe_top spfe_sva #(.BUF_DEPTH(BUF_DEPTH)) spfe_sva_i (
  .clk(clk), .rst_b(rst_b), .ce(ce), .sclk(sclk), .sel_n(sel_n),
  .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
  .write_protect_n(write_protect_n), .dat_valid(dat_valid),
  .dat_ready(dat_ready), .dat_first(dat_first), .dat_col(dat_col),
  .dat_byte(dat_byte), .op_valid(op_valid), .op_ready(op_ready),
  .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done),
  .cycle_busy_flag(cycle_busy_flag), .standby(standby),
  .write_latch(write_latch), .protect_area_bit0(protect_area_bit0),
  .protect_area_bit1(protect_area_bit1),
  .protect_area_bit2(protect_area_bit2),
  .status_write_disable(status_write_disable), .overrun(overrun));

//--- dv/spfe_master.sv
// serial bus master model driving the link pins
`timescale 1ns/1ps
module spfe_master (
  // link pins
  output logic      sclk,
  output logic      sel_n,
  output logic      mosi,
  input  wire logic sdo
);
  initial {sclk, sel_n, mosi} = 3'b000;
  // one frame; rx keeps the first byte after the opcode
  task automatic xfer(input logic [7:0] q[$], input int nbits,
                      input logic cpol, input logic fall,
                      output logic [7:0] rx);
    int i;
    rx = 8'h00;
    sclk = cpol;
    if (fall) begin
      sel_n = 1'b1;
      #200;
      sel_n = 1'b0;
    end
    #200;
    for (i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      mosi = q[i / 8][7 - i % 8];
      #80;
      sclk = 1'b1;
      if (i >= 8 && i < 16) rx = {rx[6:0], sdo};
      #80;
    end
    sclk = cpol;
    #120;
    sel_n = 1'b1;
    // stale bit inverted so it is never mistaken for data
    mosi = ~mosi;
    #200;
  endtask : xfer
endmodule : spfe_master

//--- dv/spfe_top_test.sv
// self-checking bench of the paged flash front end
`timescale 1ns/1ps
module spfe_top_test import spfe_pkg::*; ;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, write_protect_n = 1'b1;
  logic dat_ready = 1'b1, op_ready = 1'b0, op_done = 1'b0, stall = 1'b0;
  logic sclk, sel_n, mosi, miso, miso_oe_n, sdo, dat_valid, dat_first;
  logic op_valid, cycle_busy_flag, standby, write_latch, overrun;
  logic protect_area_bit0, protect_area_bit1, protect_area_bit2;
  logic status_write_disable;
  logic [7:0] dat_col, dat_byte, rx, q[$];
  spfe_op_e op_kind;
  logic [ADDR_W-1:0] op_addr;
  logic [31:0] dq[$], oq[$];
  logic [21:0] ex[4] = '{{OP_PAGE_ERASE, 19'h56700},
    {OP_SUBSECTOR_ERASE, 19'h56000}, {OP_SECTOR_ERASE, 19'h50000},
    {OP_WHOLE_ARRAY_ERASE, 19'h00000}};
  int err_total = 0, tests_run = 0, dcnt = 0, i;
  always #10 clk = ~clk;
  // released line shows the inverse, not a stale copy
  assign sdo = miso_oe_n ? ~miso : miso;
  spfe_top #(.BUF_DEPTH(2)) spfe_top_i (.clk(clk), .rst_b(rst_b),
    .ce(ce), .sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .write_protect_n(write_protect_n),
    .dat_valid(dat_valid), .dat_ready(dat_ready), .dat_first(dat_first),
    .dat_col(dat_col), .dat_byte(dat_byte), .op_valid(op_valid),
    .op_ready(op_ready), .op_kind(op_kind), .op_addr(op_addr),
    .op_done(op_done), .cycle_busy_flag(cycle_busy_flag),
    .standby(standby), .write_latch(write_latch),
    .protect_area_bit0(protect_area_bit0),
    .protect_area_bit1(protect_area_bit1),
    .protect_area_bit2(protect_area_bit2),
    .status_write_disable(status_write_disable), .overrun(overrun));
  spfe_master spfe_master_i (.sclk(sclk), .sel_n(sel_n), .mosi(mosi),
    .sdo(sdo));
  // array side: takes requests at once, finishes 200 cycles later
  always @(negedge clk) begin
    logic nr, no;
    nr = !stall;
    no = op_valid && !op_ready;
    if (dat_valid && nr) dq.push_back({dat_first, dat_col, dat_byte});
    if (no) begin
      oq.push_back({op_kind, op_addr});
      dcnt = 200;
    end
    op_done <= (dcnt == 1);
    if (dcnt > 0) dcnt--;
    op_ready <= no;
    dat_ready <= nr;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic frame(input logic [7:0] f[$], input int nb = 0,
                       input logic cpol = 1'b0);
    spfe_master_i.xfer(f, nb ? nb : 8 * f.size(), cpol, 1'b1, rx);
  endtask : frame
  task automatic wr(input logic [7:0] f[$]);
    frame('{CMD_WRITE_EN});
    frame(f);
  endtask : wr
  task automatic idle();
    int n;
    for (n = 0; n < 2000 && (n < 20 || cycle_busy_flag !== 1'b0); n++)
      @(negedge clk);
  endtask : idle
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    #1_000_000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk(miso_oe_n, 1'b1);
    chk({protect_area_bit2, protect_area_bit1, protect_area_bit0,
      status_write_disable, write_latch, cycle_busy_flag, overrun}, 0);
    repeat (5) @(negedge clk);
    spfe_master_i.xfer('{CMD_WRITE_EN}, 8, 1'b0, 1'b0, rx);
    idle();
    chk(write_latch, 1'b0);
    chk(standby, 1'b1);
    frame('{CMD_WRITE_EN});
    frame('{CMD_STATUS_READ, 8'h00});
    chk(rx, 8'h02);
    frame('{CMD_STATUS_READ, 8'h00}, 0, 1'b1);
    chk(rx, 8'h02);
    wr('{CMD_STATUS_WRITE, 8'hff});
    frame('{CMD_STATUS_READ, 8'h00});
    chk(rx, 8'h9c);
    idle();
    write_protect_n = 1'b0;
    wr('{CMD_STATUS_WRITE, 8'h04});
    frame('{CMD_STATUS_READ, 8'h00});
    chk(rx, 8'h9c);
    idle();
    write_protect_n = 1'b1;
    wr('{CMD_STATUS_WRITE, 8'h04});
    idle();
    wr('{CMD_PAGE_PROG, 8'h07, 8'h00, 8'h10, 8'haa});
    idle();
    chk(oq.size(), 0);
    chk(write_latch, 1'b0);
    dq.delete();
    stall = 1'b1;
    wr('{CMD_PAGE_PROG, 8'h06, 8'h12, 8'hff, 8'h5a, 8'ha5});
    chk(dat_valid, 1'b1);
    frame('{CMD_STATUS_READ, 8'h00});
    chk(rx, 8'h05);
    chk(standby, 1'b0);
    @(negedge clk);
    stall = 1'b0;
    idle();
    chk(dq.pop_front(), {1'b1, 8'hff, 8'h5a});
    chk(dq.pop_front(), {1'b0, 8'h00, 8'ha5});
    chk(overrun, 1'b0);
    chk(oq.pop_front(), {OP_PAGE_PROG, 19'h61200});
    wr('{CMD_STATUS_WRITE, 8'h00});
    idle();
    for (i = 0; i < 4; i++) begin
      q = '{CMD_PAGE_ERASE + 8'(i), 8'h05, 8'h67, 8'h89};
      if (i == 3) q = '{CMD_WHOLE_ARRAY_ERASE};
      wr(q);
      idle();
      chk(oq.pop_front(), ex[i]);
    end
    wr('{CMD_PAGE_WRITE, 8'h01, 8'h23, 8'h45, 8'h3c});
    idle();
    chk(oq.pop_front(), {OP_PAGE_ERASE, 19'h12300});
    chk(oq.pop_front(), {OP_PAGE_PROG, 19'h12300});
    frame('{CMD_WRITE_EN});
    frame('{CMD_PAGE_ERASE, 8'h01, 8'h00, 8'h00}, 31);
    idle();
    chk(oq.size(), 0);
    chk(write_latch, 1'b1);
    frame('{CMD_WRITE_DIS});
    chk(write_latch, 1'b0);
    wr('{CMD_SECTOR_ERASE, 8'h02, 8'h00, 8'h00});
    @(negedge clk);
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    dcnt = 0;
    @(negedge clk);
    chk({cycle_busy_flag, miso_oe_n}, 2'b01);
    repeat (10) @(negedge clk);
    frame('{CMD_STATUS_READ, 8'h00});
    chk(rx, 8'h00);
    test_done();
  end
endmodule : spfe_top_test
